// file: rtl/fsp_pkg.sv
// Constants, field layouts and carriers for the fuse and programming port
package fsp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 10;   // Reference clock rate
	localparam int STROBE_MIN_NS = 250;  // Least strobe width from host
	localparam int WRITE_NS      = 1000; // Busy time of a write
	localparam int ERASE_NS      = 4000; // Busy time of a chip erase
	localparam logic [15:0] WRITE_CYC =
		16'((WRITE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [15:0] ERASE_CYC =
		16'((ERASE_NS * CLK_MHZ + 999) / 1000);

	// ----------------------------------------------------------------
	// Strobe actions and command bytes
	// ----------------------------------------------------------------
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_ROM   = 8'h11;
	localparam logic [7:0] CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_ROM   = 8'h03;

	// ----------------------------------------------------------------
	// Fuse fields (0 = programmed) and reset values
	// ----------------------------------------------------------------
	localparam int LF_DIV8_BIT = 7;
	localparam int LF_OUT_BIT  = 6;
	localparam int LF_SUT_LSB  = 4;
	localparam int LF_SRC_LSB  = 0;
	localparam int HF_SDL_BIT  = 5;
	localparam int HF_WDT_BIT  = 4;
	localparam int HF_KEEP_BIT = 3;
	localparam logic [7:0] LOW_FUSE_RST  = 8'h62;
	localparam logic [7:0] HIGH_FUSE_RST = 8'hDF;
	localparam logic [7:0] EXT_FUSE_RST  = 8'hFF;
	localparam logic [7:0] LOCK_RST      = 8'hFF;
	localparam logic [3:0] SRC_RC_8MHZ   = 4'h2;

	// ----------------------------------------------------------------
	// Signature space
	// ----------------------------------------------------------------
	localparam logic [7:0] SIG_LAST    = 8'h02; // Last id byte address
	localparam logic [7:0] SERIAL_BASE = 8'h03; // First serial byte
	localparam int         SERIAL_LEN  = 9;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       sysclk_div_eight;
		logic       sysclk_pin_out;
		logic [1:0] startup_delay_select;
		logic [3:0] clock_source_select;
		logic       rc_8mhz_selected;
		logic       serial_download_enable;
		logic       watchdog_forced_on;
		logic       eeprom_keep_on_erase;
	} fsp_cfg_s;

	typedef struct packed {
		logic        page_load;
		logic        flash_write;
		logic        rom_write;
		logic        chip_erase;
		logic        keep_rom;
		logic [7:0]  flash_page_index;
		logic [6:0]  flash_word_in_page;
		logic [10:0] rom_byte_index;
		logic [15:0] wdata;
	} fsp_mem_req_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN  = 2'h1,
		ST_DONE = 2'h3
	} fsp_state_e;

endpackage

// file: rtl/fsp_busy_timer.sv
// Down-counter that times one programming operation
`timescale 1ns/1ps
`default_nettype none
module fsp_busy_timer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        start,
	input  wire logic [15:0] load,
	// Status
	output logic             busy,
	output logic             done
);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic [15:0] count;      // Cycles left
	logic [15:0] next_count; // Value for next edge

	// Start while counting is ignored
	assign next_count = start && !busy ? load :
		busy ? count - 16'h0001 : 16'h0000;

	// Counter register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
		end else begin
			count <= next_count;
		end
	end

	assign busy = count != 16'h0000;
	assign done = count == 16'h0001;

endmodule
`default_nettype wire

// file: rtl/fsp_fuse_port.sv
// Fuse store, signature space and parallel programming port
//
// How it works
// - Low fuse: div8, clock out, startup, source
// - Source pattern 0010 selects 8 MHz RC
// - Clock-out fuse puts sysclk on port bit
// - High bit 5 serial download, serial-locked
// - High bit 4 forces watchdog on
// - High bit 3 keeps EEPROM on erase
// - Chip erase leaves fuses untouched
// - Fuse writes refused once lock one programmed
// - Fuses latched on programming entry and exit, act after
// - EEPROM keep fuse acts immediately
// - Fuses latched at power-up too
// - Three id bytes at 0x000..0x002, always readable
// - Trim byte at 0x000 high, loaded at reset
// - Nine serial number bytes in signature space
// - Flash 256 pages of 128 words
// - EEPROM 2K bytes in 8-byte pages
// - Action bits pick strobe pulse action
// - Write or read pulse runs loaded command
// - Ready low while busy, high when ready
// - Data bus driven only while read low
// - Read-back 0 means programmed
// - Action codes: address, data, command, idle
// - Command byte encodings as listed
`timescale 1ns/1ps
`default_nettype none
module fsp_fuse_port #(
	parameter logic [7:0] ID_BYTE0 = 8'hA5, // Arbitrary id value
	parameter logic [7:0] ID_BYTE1 = 8'h5A, // Arbitrary id value
	parameter logic [7:0] ID_BYTE2 = 8'h3C, // Arbitrary id value
	parameter logic [7:0] RC_TRIM  = 8'h80, // Factory trim byte
	parameter logic [71:0] SERIAL_NUM = 72'h0 // Per-part number
) (
	// Clock and reset
	input  wire logic                  REF_CLK,
	input  wire logic                  RST_N,
	// Mode
	input  wire logic                  PROG_MODE,
	input  wire logic                  SERIAL_MODE,
	// Programming strobes
	input  wire logic                  ACTION_STROBE_PIN,
	input  wire logic                  STROBE_ACTION_HI,
	input  wire logic                  STROBE_ACTION_LO,
	input  wire logic                  WR_N,
	input  wire logic                  OE_N,
	input  wire logic                  BYTE_SEL_FIRST,
	input  wire logic                  BYTE_SEL_SECOND,
	input  wire logic                  PAGE_BUFFER_LATCH,
	output logic                       READY_BUSY_OUT,
	// Data bus
	input  wire logic [7:0]            DATA_IN,
	output logic [7:0]                 DATA_OUT,
	output logic                       DATA_OE,
	// Memory array side
	input  wire logic [15:0]           FLASH_RDATA,
	input  wire logic [7:0]            ROM_RDATA,
	output fsp_pkg::fsp_mem_req_s      MEM_REQ,
	// Configuration
	output fsp_pkg::fsp_cfg_s          CFG,
	output logic [7:0]                 RC_TRIM_REGISTER,
	output logic                       LOCK_BIT_ONE,
	// Clock output pin
	input  wire logic                  PORT_B0_VALUE,
	output logic                       CLOCK_OUT_PORT_BIT
);

	// ----------------------------------------------------------------
	// Stored state
	// ----------------------------------------------------------------
	logic [7:0] fuse_low;     // Nonvolatile low fuse
	logic [7:0] fuse_high;    // Nonvolatile high fuse
	logic [7:0] fuse_ext;     // Nonvolatile extended fuse
	logic [7:0] locks;        // Nonvolatile lock byte
	logic [7:0] work_low;     // Latched low copy
	logic [7:0] work_high;    // Latched high copy
	logic       keep_now;     // Immediate EEPROM keep copy
	logic       power_up;     // First cycle after reset
	logic [7:0] rc_trim;      // Oscillator trim register
	logic [7:0] cmd;          // Last loaded command
	logic [7:0] addr_lo;      // Address low byte
	logic [7:0] addr_hi;      // Address high byte
	logic [7:0] addr_ext;     // Address extended byte
	logic [7:0] data_lo;      // Data low byte
	logic [7:0] data_hi;      // Data high byte
	logic [7:0] rd_data;      // Registered read byte
	logic       prog_q;       // Mode level last cycle
	logic       strobe_q;     // Action strobe last cycle
	logic       wr_q;         // Write strobe last cycle
	logic       page_buffer_latch_q;      // Page latch last cycle
	logic       erase_run;    // Running op is an erase
	fsp_pkg::fsp_state_e  state;
	fsp_pkg::fsp_state_e  next_state;
	fsp_pkg::fsp_mem_req_s req;

	// ----------------------------------------------------------------
	// Edge and mode decode
	// ----------------------------------------------------------------
	logic       prog_rise;    // Entering programming mode
	logic       prog_fall;    // Leaving programming mode
	logic       latch_now;    // Copy fuses to working set
	logic       act_pulse;    // Action strobe rising
	logic       wr_pulse;     // Write strobe falling
	logic       page_buffer_latch_pulse;  // Page latch rising
	logic       ready;        // No operation in hand
	logic [1:0] action;       // Action select pair
	logic [1:0] byte_sel;     // Second and first selects
	logic       fuse_locked;  // Lock one programmed
	logic       mem_locked;   // Array writes locked
	logic       do_erase;     // Start chip erase
	logic       do_fuse;      // Commit a fuse byte
	logic       do_lock;      // Commit lock bits
	logic       do_flash;     // Start page write
	logic       do_rom;       // Start EEPROM write
	logic       start_op;     // Any timed operation
	logic       timer_done;   // Timer final cycle
	logic [7:0] new_high;     // High fuse after write

	assign prog_rise   = PROG_MODE && !prog_q;
	assign prog_fall   = !PROG_MODE && prog_q;
	assign latch_now   = power_up || prog_rise || prog_fall;
	assign act_pulse   = PROG_MODE && ACTION_STROBE_PIN && !strobe_q;
	assign wr_pulse    = PROG_MODE && !WR_N && wr_q;
	assign page_buffer_latch_pulse = PROG_MODE && PAGE_BUFFER_LATCH && !page_buffer_latch_q;
	assign action      = {STROBE_ACTION_HI, STROBE_ACTION_LO};
	assign byte_sel    = {BYTE_SEL_SECOND, BYTE_SEL_FIRST};
	assign ready       = state == fsp_pkg::ST_IDLE;
	assign fuse_locked = !locks[0];
	assign mem_locked  = !locks[0];

	// Commands start only when ready
	assign do_erase = wr_pulse && ready
		&& cmd == fsp_pkg::CMD_ERASE;
	assign do_fuse  = wr_pulse && ready && !fuse_locked
		&& cmd == fsp_pkg::CMD_WR_FUSE;
	assign do_lock  = wr_pulse && ready
		&& cmd == fsp_pkg::CMD_WR_LOCK;
	assign do_flash = wr_pulse && ready && !mem_locked
		&& cmd == fsp_pkg::CMD_WR_FLASH;
	assign do_rom   = wr_pulse && ready && !mem_locked
		&& cmd == fsp_pkg::CMD_WR_ROM;
	assign start_op = do_erase || do_fuse || do_lock
		|| do_flash || do_rom;

	// Serial mode cannot change the download bit
	assign new_high = SERIAL_MODE ?
		{DATA_IN[7:6], fuse_high[fsp_pkg::HF_SDL_BIT],
		DATA_IN[4:0]} : DATA_IN;

	// ----------------------------------------------------------------
	// Busy sequencing
	// ----------------------------------------------------------------
	fsp_busy_timer fsp_busy_timer_i (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.start (start_op),
		.load  (do_erase ? fsp_pkg::ERASE_CYC : fsp_pkg::WRITE_CYC),
		.busy  (),
		.done  (timer_done)
	);

	// Idle, run until timer ends, one finishing cycle
	always_comb begin
		next_state = state;
		unique case (state)
			fsp_pkg::ST_IDLE: begin
				if (start_op) begin
					next_state = fsp_pkg::ST_RUN;
				end
			end
			fsp_pkg::ST_RUN: begin
				if (timer_done) begin
					next_state = fsp_pkg::ST_DONE;
				end
			end
			fsp_pkg::ST_DONE: begin
				next_state = fsp_pkg::ST_IDLE;
			end
			default: begin
				next_state = fsp_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= fsp_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign READY_BUSY_OUT = ready;

	// ----------------------------------------------------------------
	// Strobe edge history
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prog_q   <= 1'b0;
			strobe_q <= 1'b0;
			wr_q     <= 1'b1;
			page_buffer_latch_q  <= 1'b0;
			power_up <= 1'b1;
		end else begin
			prog_q   <= PROG_MODE;
			strobe_q <= ACTION_STROBE_PIN;
			wr_q     <= WR_N;
			page_buffer_latch_q  <= PAGE_BUFFER_LATCH;
			power_up <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Loading command, address and data bytes
	// ----------------------------------------------------------------
	// Kept so repeated accesses reload nothing
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd      <= 8'h00;
			addr_lo  <= 8'h00;
			addr_hi  <= 8'h00;
			addr_ext <= 8'h00;
			data_lo  <= 8'h00;
			data_hi  <= 8'h00;
		end else if (act_pulse) begin
			unique case (action)
				fsp_pkg::ACT_ADDR: begin
					if (BYTE_SEL_SECOND) begin
						addr_ext <= DATA_IN;
					end else if (BYTE_SEL_FIRST) begin
						addr_hi <= DATA_IN;
					end else begin
						addr_lo <= DATA_IN;
					end
				end
				fsp_pkg::ACT_DATA: begin
					if (BYTE_SEL_FIRST) begin
						data_hi <= DATA_IN;
					end else begin
						data_lo <= DATA_IN;
					end
				end
				fsp_pkg::ACT_CMD: begin
					cmd <= DATA_IN;
				end
				fsp_pkg::ACT_IDLE: begin
					cmd <= cmd;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Nonvolatile fuses and locks
	// ----------------------------------------------------------------
	// Erase resets only the locks, once finished
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fuse_low  <= fsp_pkg::LOW_FUSE_RST;
			fuse_high <= fsp_pkg::HIGH_FUSE_RST;
			fuse_ext  <= fsp_pkg::EXT_FUSE_RST;
			locks     <= fsp_pkg::LOCK_RST;
		end else begin
			if (do_fuse) begin
				unique case (byte_sel)
					2'h0: fuse_low <= DATA_IN;
					2'h1: fuse_high <= new_high;
					2'h2: fuse_ext <= DATA_IN;
					2'h3: fuse_low <= fuse_low;
				endcase
			end
			if (do_lock) begin
				locks <= locks & DATA_IN; // Bits only program
			end else if (state == fsp_pkg::ST_DONE && erase_run) begin
				locks <= fsp_pkg::LOCK_RST;
			end
		end
	end

	// ----------------------------------------------------------------
	// Working copies
	// ----------------------------------------------------------------
	// Mode changes reach the device only at a latch, the EEPROM keep bit at once
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			work_low  <= fsp_pkg::LOW_FUSE_RST;
			work_high <= fsp_pkg::HIGH_FUSE_RST;
			keep_now  <= fsp_pkg::HIGH_FUSE_RST[fsp_pkg::HF_KEEP_BIT];
		end else begin
			if (latch_now) begin
				work_low  <= fuse_low;
				work_high <= fuse_high;
			end
			if (do_fuse && byte_sel == 2'h1) begin
				keep_now <= new_high[fsp_pkg::HF_KEEP_BIT];
			end else if (latch_now) begin
				keep_now <= fuse_high[fsp_pkg::HF_KEEP_BIT];
			end
		end
	end

	// Trim byte loaded by reset
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rc_trim <= RC_TRIM;
		end else begin
			rc_trim <= rc_trim;
		end
	end

	// Programmed fuse is 0, so outputs of single fuse bits invert it; LOCK_BIT_ONE passes locks[0] as is
	assign CFG.sysclk_div_eight       = !work_low[fsp_pkg::LF_DIV8_BIT];
	assign CFG.sysclk_pin_out         = !work_low[fsp_pkg::LF_OUT_BIT];
	assign CFG.startup_delay_select   =
		work_low[fsp_pkg::LF_SUT_LSB +: 2];
	assign CFG.clock_source_select    =
		work_low[fsp_pkg::LF_SRC_LSB +: 4];
	assign CFG.rc_8mhz_selected       = work_low[fsp_pkg::LF_SRC_LSB +: 4]
		== fsp_pkg::SRC_RC_8MHZ;
	assign CFG.serial_download_enable =
		!work_high[fsp_pkg::HF_SDL_BIT];
	assign CFG.watchdog_forced_on     =
		!work_high[fsp_pkg::HF_WDT_BIT];
	assign CFG.eeprom_keep_on_erase   = !keep_now;
	assign RC_TRIM_REGISTER           = rc_trim;
	assign LOCK_BIT_ONE               = locks[0];

	// System clock replaces the port value when the fuse asks
	assign CLOCK_OUT_PORT_BIT = CFG.sysclk_pin_out ?
		REF_CLK : PORT_B0_VALUE;

	// ----------------------------------------------------------------
	// Memory requests
	// ----------------------------------------------------------------
	// Page index takes address low bit 7
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			req       <= '0;
			erase_run <= 1'b0;
		end else begin
			req.page_load   <= page_buffer_latch_pulse;
			req.flash_write <= do_flash;
			req.rom_write   <= do_rom;
			req.chip_erase  <= do_erase;
			req.keep_rom    <= !keep_now;
			req.flash_word_in_page <= addr_lo[6:0];
			req.flash_page_index   <= {addr_hi[6:0], addr_lo[7]};
			req.rom_byte_index     <= {addr_hi[2:0], addr_lo};
			req.wdata              <= {data_hi, data_lo};
			if (start_op) begin
				erase_run <= do_erase;
			end
		end
	end

	assign MEM_REQ = req;

	// ----------------------------------------------------------------
	// Read-back path
	// ----------------------------------------------------------------
	logic [7:0] sig_byte;   // Signature space byte
	logic [7:0] fuse_byte;  // Fuse or lock byte
	logic [7:0] read_mux;   // Byte chosen by command
	logic [7:0] ser_off;    // Offset into serial number

	assign ser_off = addr_lo - fsp_pkg::SERIAL_BASE;

	// Id bytes never consult the locks
	assign sig_byte =
		BYTE_SEL_FIRST ? (addr_lo == 8'h00 ? rc_trim : 8'hFF) :
		addr_lo == 8'h00 ? ID_BYTE0 :
		addr_lo == 8'h01 ? ID_BYTE1 :
		addr_lo == fsp_pkg::SIG_LAST ? ID_BYTE2 :
		ser_off < 8'(fsp_pkg::SERIAL_LEN) ?
		SERIAL_NUM[{ser_off[3:0], 3'h0} +: 8] : 8'hFF;

	// Stored bits as is: 0 is programmed
	assign fuse_byte =
		byte_sel == 2'h0 ? fuse_low :
		byte_sel == 2'h1 ? locks :
		byte_sel == 2'h2 ? fuse_ext : fuse_high;

	assign read_mux =
		cmd == fsp_pkg::CMD_RD_SIG   ? sig_byte :
		cmd == fsp_pkg::CMD_RD_FUSE  ? fuse_byte :
		cmd == fsp_pkg::CMD_RD_FLASH ?
		(BYTE_SEL_FIRST ? FLASH_RDATA[15:8] : FLASH_RDATA[7:0]) :
		cmd == fsp_pkg::CMD_RD_ROM   ? ROM_RDATA : 8'hFF;

	// Read byte, refreshed every cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_data <= 8'hFF;
		end else begin
			rd_data <= read_mux;
		end
	end

	assign DATA_OUT = rd_data;
	assign DATA_OE  = PROG_MODE && !OE_N;

endmodule
`default_nettype wire

// file: tb/fsp_fuse_port_chk.sv
// Port-level assertions for the fuse and programming port
`timescale 1ns/1ps
`default_nettype none
module fsp_fuse_port_chk (
	// Clock and reset
	input wire logic                  REF_CLK,
	input wire logic                  RST_N,
	// Port pins
	input wire logic                  PROG_MODE,
	input wire logic                  OE_N,
	input wire logic                  READY_BUSY_OUT,
	input wire logic                  DATA_OE,
	input wire logic                  PORT_B0_VALUE,
	input wire logic                  CLOCK_OUT_PORT_BIT,
	input wire logic                  LOCK_BIT_ONE,
	// Carriers
	input wire fsp_pkg::fsp_mem_req_s MEM_REQ,
	input wire fsp_pkg::fsp_cfg_s     CFG
);
	// ------------------------------------------------------------
	// Clocking
	// ------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	// Shortest busy stretch
	sequence s_busy_hold;
		!READY_BUSY_OUT [*8];
	endsequence
	// Write pulse inside busy
	sequence s_write_pulse;
		!READY_BUSY_OUT ##1 !MEM_REQ.flash_write;
	endsequence

	property p_bus_drive;
		DATA_OE == (PROG_MODE && !OE_N);
	endproperty
	a_bus_drive: assert property (p_bus_drive)
		else $error("data bus drive wrong");
	property p_src_decode;
		CFG.rc_8mhz_selected == (CFG.clock_source_select == 4'h2);
	endproperty
	a_src_decode: assert property (p_src_decode)
		else $error("rc source decode wrong");
	property p_pin_pass;
		!CFG.sysclk_pin_out |-> CLOCK_OUT_PORT_BIT == PORT_B0_VALUE;
	endproperty
	a_pin_pass: assert property (p_pin_pass)
		else $error("port bit not passed");
	property p_busy_min;
		$fell(READY_BUSY_OUT) |-> s_busy_hold;
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("busy too short");
	property p_busy_max;
		$fell(READY_BUSY_OUT) |-> ##[1:60] READY_BUSY_OUT;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy never ends");
	property p_write_busy;
		MEM_REQ.flash_write |-> s_write_pulse;
	endproperty
	a_write_busy: assert property (p_write_busy)
		else $error("write pulse outside busy");
	property p_erase_keeps;
		MEM_REQ.chip_erase |-> !READY_BUSY_OUT ##1 $stable(CFG) [*8];
	endproperty
	a_erase_keeps: assert property (p_erase_keeps)
		else $error("erase moved config");
	property p_latch_hold;
		PROG_MODE && $past(PROG_MODE) |-> $stable(CFG[11:1]);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("config moved in programming");
	property p_lock_gate;
		!LOCK_BIT_ONE |-> !MEM_REQ.flash_write;
	endproperty
	a_lock_gate: assert property (p_lock_gate)
		else $error("array write while locked");
endmodule
bind fsp_fuse_port fsp_fuse_port_chk fsp_fuse_port_chk_i (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .PROG_MODE(PROG_MODE),
	.OE_N(OE_N), .READY_BUSY_OUT(READY_BUSY_OUT), .DATA_OE(DATA_OE),
	.PORT_B0_VALUE(PORT_B0_VALUE), .CLOCK_OUT_PORT_BIT(CLOCK_OUT_PORT_BIT),
	.LOCK_BIT_ONE(LOCK_BIT_ONE), .MEM_REQ(MEM_REQ), .CFG(CFG));
`default_nettype wire

// file: tb/fsp_programmer.sv
// Parallel programmer model driving the strobe pins and bus
`timescale 1ns/1ps
`default_nettype none
module fsp_programmer (
	// Clock and bus level
	input  wire logic       clk,
	input  wire logic [7:0] bus,
	// Strobes and selects
	output var logic        strobe,
	output var logic        act_hi,
	output var logic        act_lo,
	output var logic        wr_n,
	output var logic        oe_n,
	output var logic        bs1,
	output var logic        bs2,
	output var logic        page_buffer_latch,
	// Data driven onto the bus
	output var logic [7:0]  data
);
	// Idle: action idle, strobes off
	initial begin
		{strobe, act_hi, act_lo, wr_n, oe_n, bs1, bs2, page_buffer_latch} = 8'h78;
		data = 8'h00;
	end
	// Action bits settle before the strobe
	task automatic load(input logic [1:0] a, input logic b1,
		input logic [7:0] v);
		@(negedge clk);
		{act_hi, act_lo, bs2, bs1, data} = {a, 1'b0, b1, v};
		@(negedge clk);
		strobe = 1'b1;
		repeat (3) @(negedge clk);
		strobe = 1'b0;
		act_hi = 1'b1;
		act_lo = 1'b1;
		@(negedge clk);
	endtask
	task automatic cmd(input logic [7:0] v);
		load(fsp_pkg::ACT_CMD, 1'b0, v);
	endtask
	task automatic adr(input logic b1, input logic [7:0] v);
		load(fsp_pkg::ACT_ADDR, b1, v);
	endtask
	task automatic dat(input logic b1, input logic [7:0] v);
		load(fsp_pkg::ACT_DATA, b1, v);
	endtask
	// Page latch pulse
	task automatic latch_page();
		page_buffer_latch = 1'b1;
		repeat (3) @(negedge clk);
		page_buffer_latch = 1'b0;
		@(negedge clk);
	endtask
	// Bus released while device answers, inverted
	task automatic rd(input logic b2, b1, output logic [7:0] v);
		{bs2, bs1, oe_n} = {b2, b1, 1'b0};
		data = ~data;
		repeat (3) @(negedge clk);
		v = bus;
		oe_n = 1'b1;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

// file: tb/fsp_fuse_port_tb_top.sv
// Self-checking bench for the fuse and programming port
`timescale 1ns/1ps
`default_nettype none
module fsp_fuse_port_tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                  clk, rst_n, prog_mode, serial_mode, pb0;
	logic                  stb, ahi, alo, wr_n, oe_n, bs1, bs2, page_buffer_latch;
	logic [7:0]            pdata, dout, trim, bus, v;
	logic                  ready, doe, lock1, cko;
	fsp_pkg::fsp_mem_req_s mreq, got;
	fsp_pkg::fsp_cfg_s     cfg;
	int                    fails = 0, checks_done = 0, n;

	// Device drives only when enabled
	assign bus = doe ? dout : pdata;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	fsp_fuse_port fsp_fuse_port_i (.REF_CLK(clk), .RST_N(rst_n),
		.PROG_MODE(prog_mode), .SERIAL_MODE(serial_mode),
		.ACTION_STROBE_PIN(stb), .STROBE_ACTION_HI(ahi),
		.STROBE_ACTION_LO(alo), .WR_N(wr_n), .OE_N(oe_n),
		.BYTE_SEL_FIRST(bs1), .BYTE_SEL_SECOND(bs2),
		.PAGE_BUFFER_LATCH(page_buffer_latch), .READY_BUSY_OUT(ready), .DATA_IN(bus),
		.DATA_OUT(dout), .DATA_OE(doe), .FLASH_RDATA(16'h1234),
		.ROM_RDATA(8'h5A), .MEM_REQ(mreq), .CFG(cfg),
		.RC_TRIM_REGISTER(trim), .LOCK_BIT_ONE(lock1),
		.PORT_B0_VALUE(pb0), .CLOCK_OUT_PORT_BIT(cko));
	fsp_programmer pgm (.clk(clk), .bus(bus), .strobe(stb),
		.act_hi(ahi), .act_lo(alo), .wr_n(wr_n), .oe_n(oe_n), .bs1(bs1),
		.bs2(bs2), .page_buffer_latch(page_buffer_latch), .data(pdata));

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic bad(input string m);
		fails++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic check(input logic [15:0] g, e);
		checks_done++;
		if (g !== e) bad($sformatf("got %h want %h", g, e));
	endtask

	// Write pulse; counts busy cycles, keeps any write or erase pulse
	task automatic run_cmd(input logic b2, b1, output int n);
		int k;
		n = 0;
		got = '0;
		{pgm.bs2, pgm.bs1} = {b2, b1};
		pgm.wr_n = 1'b0;
		for (k = 0; k < 200; k++) begin
			@(negedge clk);
			if (k == 3) pgm.wr_n = 1'b1;
			if (mreq.flash_write | mreq.rom_write | mreq.chip_erase) got = mreq;
			n += (ready !== 1'b1);
			if (k > 3 && ready === 1'b1) break;
		end
		// Bound used up
		if (ready !== 1'b1) begin
			bad("ready never returned");
			complete_run();
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_defaults();
		check({4'h0, cfg}, 16'h0A2C);
		check({8'h0, trim}, 16'h0080);
		check({15'h0, ready}, 16'h1);
		check({15'h0, cko}, {15'h0, pb0});
	endtask
	// Id and serial bytes, past the end, then trim byte
	task automatic t_signature();
		int a;
		prog_mode = 1'b1;
		repeat (3) @(negedge clk);
		pgm.cmd(fsp_pkg::CMD_RD_SIG);
		for (a = 0; a < 13; a++) begin
			pgm.adr(1'b0, 8'(a));
			pgm.rd(1'b0, 1'b0, v);
			check(v, a == 0 ? 8'hA5 : a == 1 ? 8'h5A : a == 2 ? 8'h3C :
				a < 12 ? 8'h00 : 8'hFF);
		end
		pgm.adr(1'b0, 8'h00);
		pgm.rd(1'b0, 1'b1, v);
		check(v, 8'h80);
	endtask
	// Fuse writes act on exit, keep fuse at once
	task automatic t_fuses();
		pgm.cmd(fsp_pkg::CMD_WR_FUSE);
		pgm.dat(1'b0, 8'h22);
		run_cmd(1'b0, 1'b0, n);
		check(16'(n >= 10), 16'h1);
		serial_mode = 1'b1;
		pgm.dat(1'b0, 8'hF7);
		run_cmd(1'b0, 1'b1, n);
		serial_mode = 1'b0;
		check({4'h0, cfg}, 16'h0A2D);
		pgm.cmd(fsp_pkg::CMD_RD_FUSE);
		pgm.rd(1'b0, 1'b0, v);
		check(v, 8'h22);
		pgm.rd(1'b1, 1'b1, v);
		check(v, 8'hD7);
		prog_mode = 1'b0;
		repeat (3) @(negedge clk);
		check({4'h0, cfg}, 16'h0E2D);
		// Clock pin looked at clear of its edges
		#10 check({15'h0, cko}, 16'h0);
		#50 check({15'h0, cko}, 16'h1);
	endtask
	// Flash page and word split, EEPROM index, reads
	task automatic t_arrays();
		@(negedge clk);
		prog_mode = 1'b1;
		repeat (3) @(negedge clk);
		pgm.cmd(fsp_pkg::CMD_WR_FLASH);
		pgm.adr(1'b0, 8'h85);
		pgm.adr(1'b1, 8'h12);
		pgm.dat(1'b0, 8'h34);
		pgm.dat(1'b1, 8'h56);
		fork
			pgm.latch_page();
			#100 check({15'h0, mreq.page_load}, 16'h1);
		join
		run_cmd(1'b0, 1'b1, n);
		check({8'h0, got.flash_page_index}, 16'h0025);
		check({9'h0, got.flash_word_in_page}, 16'h0005);
		check(got.wdata, 16'h5634);
		pgm.cmd(fsp_pkg::CMD_WR_ROM);
		run_cmd(1'b0, 1'b0, n);
		check({got.rom_write, 4'h0, got.rom_byte_index}, 16'h8285);
		pgm.cmd(fsp_pkg::CMD_RD_FLASH);
		pgm.rd(1'b0, 1'b1, v);
		check(v, 8'h12);
		pgm.cmd(fsp_pkg::CMD_RD_ROM);
		pgm.rd(1'b0, 1'b0, v);
		check(v, 8'h5A);
	endtask
	// Locks refuse writes; erase clears locks only
	task automatic t_lock_erase();
		pgm.cmd(fsp_pkg::CMD_WR_LOCK);
		pgm.dat(1'b0, 8'hFE);
		run_cmd(1'b0, 1'b0, n);
		check({15'h0, lock1}, 16'h0);
		pgm.cmd(fsp_pkg::CMD_WR_FUSE);
		pgm.dat(1'b0, 8'hFF);
		run_cmd(1'b0, 1'b0, n);
		pgm.cmd(fsp_pkg::CMD_WR_FLASH);
		run_cmd(1'b0, 1'b0, n);
		check({15'h0, got.flash_write}, 16'h0);
		pgm.cmd(fsp_pkg::CMD_ERASE);
		run_cmd(1'b0, 1'b0, n);
		check(16'(n >= 40), 16'h1);
		check({14'h0, got.chip_erase, got.keep_rom}, 16'h3);
		check({15'h0, lock1}, 16'h1);
		pgm.cmd(fsp_pkg::CMD_RD_FUSE);
		pgm.rd(1'b0, 1'b0, v);
		check(v, 8'h22);
	endtask

	// Reset, then scenarios
	initial begin
		{rst_n, prog_mode, serial_mode, pb0} = 4'h1;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		t_defaults();
		t_signature();
		t_fuses();
		t_arrays();
		t_lock_erase();
		complete_run();
	end
endmodule
`default_nettype wire
